// ===== src/cpu8_timing_pkg.sv
// Purpose: Shared types and constants for the instruction decode and timing block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Opcodes follow the standard encoding of the 8-bit accumulator instruction set.
package cpu8_timing_pkg;

    // ----------------------------------------------------------------
    // Widths and field positions
    // ----------------------------------------------------------------
    localparam int          ADDR_W          = 16;
    localparam int          CYC_W           = 4;
    localparam int          BANK_LO_POS     = 3;
    localparam int          BANK_HI_POS     = 4;
    localparam int          SPECIAL_SEL_POS = 7;
    localparam int          PAGE_LOW_BITS   = 11;

    // ----------------------------------------------------------------
    // Opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0]  OP_NOP          = 8'h00;
    localparam logic [7:0]  OP_SPARE        = 8'hA5;
    localparam logic [4:0]  OP_ABS_JMP_LO   = 5'h01;
    localparam logic [4:0]  OP_ABS_CALL_LO  = 5'h11;
    localparam logic [7:0]  OP_LONG_JMP     = 8'h02;
    localparam logic [7:0]  OP_LONG_CALL    = 8'h12;
    localparam logic [7:0]  OP_RET          = 8'h22;
    localparam logic [7:0]  OP_INT_RET      = 8'h32;
    localparam logic [7:0]  OP_SHORT_JMP    = 8'h80;
    localparam logic [7:0]  OP_JMP_IND      = 8'h73;
    localparam logic [7:0]  OP_BIT_CLR_JMP  = 8'h10;
    localparam logic [7:0]  OP_JB           = 8'h20;
    localparam logic [7:0]  OP_JNB          = 8'h30;
    localparam logic [7:0]  OP_JC           = 8'h40;
    localparam logic [7:0]  OP_JNC          = 8'h50;
    localparam logic [7:0]  OP_JZ           = 8'h60;
    localparam logic [7:0]  OP_JNZ          = 8'h70;
    localparam logic [7:0]  OP_CMP_A_IMM    = 8'hB4;
    localparam logic [7:0]  OP_CMP_A_DIR    = 8'hB5;
    localparam logic [6:0]  OP_CMP_IND_HI   = 7'h5B;
    localparam logic [4:0]  OP_CMP_REG_HI   = 5'h17;
    localparam logic [4:0]  OP_DEC_REG_HI   = 5'h1B;
    localparam logic [7:0]  OP_DEC_DIR      = 8'hD5;
    localparam logic [7:0]  OP_CODE_DP      = 8'h93;
    localparam logic [7:0]  OP_CODE_PC      = 8'h83;
    localparam logic [7:0]  OP_XIN_IND      = 8'hE2;
    localparam logic [7:0]  OP_XIN_IND1     = 8'hE3;
    localparam logic [7:0]  OP_XIN_DP       = 8'hE0;
    localparam logic [7:0]  OP_XOUT_IND     = 8'hF2;
    localparam logic [7:0]  OP_XOUT_IND1    = 8'hF3;
    localparam logic [7:0]  OP_XOUT_DP      = 8'hF0;
    localparam logic [6:0]  OP_NIBBLE_HI    = 7'h6B;
    localparam logic [7:0]  OP_MOV_DIR_DIR  = 8'h85;
    localparam logic [7:0]  OP_LOAD_DP      = 8'h90;
    localparam logic [7:0]  OP_ANL_DIR_IMM  = 8'h53;
    localparam logic [7:0]  OP_ORL_DIR_IMM  = 8'h43;
    localparam logic [7:0]  OP_XRL_DIR_IMM  = 8'h63;
    localparam logic [7:0]  OP_ANL_DIR_A    = 8'h52;
    localparam logic [7:0]  OP_ORL_DIR_A    = 8'h42;
    localparam logic [7:0]  OP_XRL_DIR_A    = 8'h62;
    localparam logic [7:0]  OP_PUSH         = 8'hC0;
    localparam logic [7:0]  OP_POP          = 8'hD0;
    localparam logic [7:0]  OP_MUL          = 8'hA4;
    localparam logic [7:0]  OP_DIV          = 8'h84;

    // ----------------------------------------------------------------
    // Lengths and base cycle counts (not-taken figure for branches)
    // ----------------------------------------------------------------
    localparam logic [1:0]  LEN_1 = 2'h1;
    localparam logic [1:0]  LEN_2 = 2'h2;
    localparam logic [1:0]  LEN_3 = 2'h3;
    localparam logic [CYC_W-1:0] CYC_1 = 4'h1;
    localparam logic [CYC_W-1:0] CYC_2 = 4'h2;
    localparam logic [CYC_W-1:0] CYC_3 = 4'h3;
    localparam logic [CYC_W-1:0] CYC_4 = 4'h4;
    localparam logic [CYC_W-1:0] CYC_5 = 4'h5;
    localparam logic [CYC_W-1:0] CYC_8 = 4'h8;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        K_PLAIN, K_REL, K_ABS, K_LONG, K_IND_JMP, K_RET,
        K_CODE_DP, K_CODE_PC, K_NIBBLE, K_BIT_CLR
    } kind_type;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] operand1;
        logic [7:0] operand2;
    } instr_type;

    typedef struct packed {
        kind_type         kind;
        logic [1:0]       length;
        logic [CYC_W-1:0] cycles;
        logic             conditional;
        logic             rel_in_third;
    } class_type;

    typedef struct packed {
        logic [1:0]        length;
        logic [CYC_W-1:0]  cycles;
        logic              taken;
        logic              target_valid;
        logic [ADDR_W-1:0] target;
        logic [ADDR_W-1:0] code_addr;
        logic              clear_bit;
        logic [4:0]        bank_reg_addr;
        logic [4:0]        pointer_reg_addr;
        logic [7:0]        data_addr;
        logic              direct_is_special;
        logic [7:0]        acc_out;
        logic [7:0]        mem_out;
    } result_type;

endpackage

// ===== src/cpu8_opcode_class.sv
// Purpose: Opcode to kind, byte length and base cycle count.
// Assumes: Purely combinational.
// Notes:   Unlisted opcodes fall back on the operand-form pattern of the low nibble.
`timescale 1ns/1ps
module cpu8_opcode_class
    import cpu8_timing_pkg::*;
(
    input  wire logic [7:0] opcode,
    output class_type       cls
);
    always_comb begin
        cls = '{kind: K_PLAIN, length: LEN_1, cycles: CYC_1,
                conditional: 1'b0, rel_in_third: 1'b0};
        if (opcode[3:0] == 4'h4 || opcode[3:0] == 4'h5) begin
            cls.length = LEN_2;
            cls.cycles = CYC_2;
        end else if (opcode[3:1] == 3'h3) begin
            cls.cycles = CYC_2;
        end
        if (opcode[4:0] == OP_ABS_JMP_LO || opcode[4:0] == OP_ABS_CALL_LO) begin
            cls = '{kind: K_ABS, length: LEN_2, cycles: CYC_3,
                    conditional: 1'b0, rel_in_third: 1'b0};
        end else begin
            unique case (opcode) inside
                OP_LONG_JMP, OP_LONG_CALL:
                    cls = '{K_LONG, LEN_3, CYC_4, 1'b0, 1'b0};
                OP_RET, OP_INT_RET:
                    cls = '{K_RET, LEN_1, CYC_5, 1'b0, 1'b0};
                OP_SHORT_JMP:
                    cls = '{K_REL, LEN_2, CYC_3, 1'b0, 1'b0};
                OP_JMP_IND:
                    cls = '{K_IND_JMP, LEN_1, CYC_3, 1'b0, 1'b0};
                OP_JC, OP_JNC, OP_JZ, OP_JNZ:
                    cls = '{K_REL, LEN_2, CYC_2, 1'b1, 1'b0};
                OP_JB, OP_JNB:
                    cls = '{K_REL, LEN_3, CYC_3, 1'b1, 1'b1};
                OP_BIT_CLR_JMP:
                    cls = '{K_BIT_CLR, LEN_3, CYC_3, 1'b1, 1'b1};
                OP_CMP_A_IMM, OP_CMP_A_DIR, OP_DEC_DIR, [8'hB8:8'hBF]:
                    cls = '{K_REL, LEN_3, CYC_3, 1'b1, 1'b1};
                8'hB6, 8'hB7:
                    cls = '{K_REL, LEN_3, CYC_4, 1'b1, 1'b1};
                [8'hD8:8'hDF]:
                    cls = '{K_REL, LEN_2, CYC_2, 1'b1, 1'b0};
                OP_CODE_DP:
                    cls = '{K_CODE_DP, LEN_1, CYC_3, 1'b0, 1'b0};
                OP_CODE_PC:
                    cls = '{K_CODE_PC, LEN_1, CYC_3, 1'b0, 1'b0};
                OP_XIN_IND, OP_XIN_IND1, OP_XIN_DP,
                OP_XOUT_IND, OP_XOUT_IND1, OP_XOUT_DP:
                    cls = '{K_PLAIN, LEN_1, CYC_3, 1'b0, 1'b0};
                8'hD6, 8'hD7:
                    cls = '{K_NIBBLE, LEN_1, CYC_2, 1'b0, 1'b0};
                OP_MOV_DIR_DIR, OP_LOAD_DP,
                OP_ANL_DIR_IMM, OP_ORL_DIR_IMM, OP_XRL_DIR_IMM:
                    cls = '{K_PLAIN, LEN_3, CYC_3, 1'b0, 1'b0};
                OP_ANL_DIR_A, OP_ORL_DIR_A, OP_XRL_DIR_A, OP_PUSH, OP_POP:
                    cls = '{K_PLAIN, LEN_2, CYC_2, 1'b0, 1'b0};
                // Spare code decodes exactly like the no-operation code
                OP_SPARE, OP_NOP:
                    cls = '{K_PLAIN, LEN_1, CYC_1, 1'b0, 1'b0};
                OP_MUL:
                    cls = '{K_PLAIN, LEN_1, CYC_4, 1'b0, 1'b0};
                OP_DIV:
                    cls = '{K_PLAIN, LEN_1, CYC_8, 1'b0, 1'b0};
                default: ;
            endcase
        end
    end
endmodule

// ===== src/cpu8_target_calc.sv
// Purpose: Branch target and code-read address arithmetic.
// Assumes: next_addr is the address of the first byte of the following instruction.
// Notes:   Wraps modulo 64K; the program store beyond its size is the caller's concern.
`timescale 1ns/1ps
module cpu8_target_calc
    import cpu8_timing_pkg::*;
(
    input  wire kind_type          kind,
    input  wire logic              rel_in_third,
    input  wire instr_type         instr,
    input  wire logic [ADDR_W-1:0] next_addr,
    input  wire logic [7:0]        acc,
    input  wire logic [ADDR_W-1:0] data_pointer_16,
    output logic [ADDR_W-1:0]      target,
    output logic [ADDR_W-1:0]      code_addr
);
    logic [7:0]        rel;
    logic [ADDR_W-1:0] rel_ext;
    logic [ADDR_W-1:0] acc_ext;

    assign rel     = rel_in_third ? instr.operand2 : instr.operand1;
    assign rel_ext = {{(ADDR_W-8){rel[7]}}, rel};
    assign acc_ext = {{(ADDR_W-8){1'b0}}, acc};

    always_comb begin
        unique case (kind)
            K_REL, K_BIT_CLR: target = next_addr + rel_ext;
            K_ABS:     target = {next_addr[ADDR_W-1:PAGE_LOW_BITS],
                                 instr.opcode[7:5], instr.operand1};
            K_LONG:    target = {instr.operand1, instr.operand2};
            K_IND_JMP: target = data_pointer_16 + acc_ext;
            default:   target = next_addr;
        endcase
        code_addr = ((kind == K_CODE_PC) ? next_addr : data_pointer_16) + acc_ext;
    end
endmodule

// ===== src/cpu8_instruction_timing.sv
// Purpose: Decode one instruction, resolve its operands and time its execution.
// Assumes: START is taken while READY; condition and operand inputs are valid with START.
// Notes:   RESULT is registered at the accepting edge and holds until the next accept.
//
// Functional notes
// - Bank register resolves within selected bank's eight
// - Indirect operand points via active R0 or R1
// - Relative target equals next address plus offset
// - Direct address top half selects function registers
// - Absolute target stays in the same 2K page
// - Long target loads full sixteen-bit address
// - Spare opcode 0xA5 behaves as no-operation
// - Carry jumps: two bytes, 2/3 cycles
// - Bit jumps 3/4 cycles; clear variant clears
// - Indirect compare jump: three bytes, 4/5 cycles
// - Direct compare jump: three bytes, 3/4 cycles
// - Decrement jumps: direct 3/4, register 2/3
// - Both returns: one byte, five cycles
// - Long call and jump: three bytes, four cycles
// - Absolute call and jump: two bytes, three cycles
// - Code byte read: one byte, three cycles
// - External data moves: one byte, three cycles
// - Nibble exchange keeps high nibbles; 1 byte, 2 cycles
// - Direct-to-direct and pointer load: 3 bytes, 3 cycles
// - Logic into direct: immediate 3/3, accumulator 2/2
// - Short jump and indirect jump take three cycles
// - Push and pop: two bytes, two cycles
// - Untaken conditional branch ends one cycle sooner
// - Status bits 3 and 4 select register bank
`timescale 1ns/1ps
module cpu8_instruction_timing
    import cpu8_timing_pkg::*;
(
    input  wire logic              MCLK,
    input  wire logic              SYS_RST,
    input  wire logic              START,
    input  wire instr_type         INSTR,
    input  wire logic [ADDR_W-1:0] INSTR_ADDR,
    input  wire logic              COND_TRUE,
    input  wire logic [7:0]        PROGRAM_STATUS_WORD,
    input  wire logic [7:0]        POINTER_VALUE,
    input  wire logic [7:0]        INDIRECT_DATA,
    input  wire logic [7:0]        ACC,
    input  wire logic [ADDR_W-1:0] DATA_POINTER_16,
    output logic                   READY,
    output logic                   DONE,
    output result_type             RESULT
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } state_type;

    typedef struct packed {
        state_type        state;
        logic [CYC_W-1:0] remaining;
        result_type       res;
    } regs_type;

    regs_type  r_q;
    regs_type  r_d;
    class_type cls;
    logic [ADDR_W-1:0] next_addr;
    logic [ADDR_W-1:0] target;
    logic [ADDR_W-1:0] code_addr;
    logic [1:0]        bank;
    logic              accept;
    logic              taken;
    logic [ADDR_W-1:0] next_addr_q;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    cpu8_opcode_class u_class (
        .opcode (INSTR.opcode),
        .cls    (cls)
    );

    assign next_addr = INSTR_ADDR + {{(ADDR_W-2){1'b0}}, cls.length};

    cpu8_target_calc u_target (
        .kind            (cls.kind),
        .rel_in_third    (cls.rel_in_third),
        .instr           (INSTR),
        .next_addr       (next_addr),
        .acc             (ACC),
        .data_pointer_16 (DATA_POINTER_16),
        .target          (target),
        .code_addr       (code_addr)
    );

    assign bank   = {PROGRAM_STATUS_WORD[BANK_HI_POS],
                     PROGRAM_STATUS_WORD[BANK_LO_POS]};
    assign READY  = (r_q.state == ST_IDLE) || (r_q.remaining == CYC_1);
    assign DONE   = (r_q.state == ST_EXEC) && (r_q.remaining == CYC_1);
    assign accept = START && READY;
    assign taken  = cls.conditional ? COND_TRUE : (cls.kind != K_PLAIN);
    assign RESULT = r_q.res;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        unique case (r_q.state)
            ST_IDLE: ;
            ST_EXEC: begin
                r_d.remaining = r_q.remaining - CYC_1;
                if (r_q.remaining == CYC_1) begin
                    r_d.state = ST_IDLE;
                end
            end
            default: r_d.state = ST_IDLE;
        endcase
        if (accept) begin
            r_d.state      = ST_EXEC;
            // Taken conditional branches pay one extra cycle
            r_d.remaining  = cls.cycles
                           + ((cls.conditional && COND_TRUE) ? CYC_1 : 4'h0);
            r_d.res.length = cls.length;
            r_d.res.cycles = r_d.remaining;
            r_d.res.taken  = taken;
            r_d.res.target_valid = taken && (cls.kind != K_RET);
            r_d.res.target = target;
            r_d.res.code_addr = code_addr;
            r_d.res.clear_bit = (cls.kind == K_BIT_CLR) && COND_TRUE;
            r_d.res.bank_reg_addr = {bank, INSTR.opcode[2:0]};
            r_d.res.pointer_reg_addr = {bank, 2'b00, INSTR.opcode[0]};
            r_d.res.data_addr = POINTER_VALUE;
            r_d.res.direct_is_special = INSTR.operand1[SPECIAL_SEL_POS];
            // Only the low nibbles trade places
            r_d.res.acc_out = (cls.kind == K_NIBBLE)
                            ? {ACC[7:4], INDIRECT_DATA[3:0]} : ACC;
            r_d.res.mem_out = (cls.kind == K_NIBBLE)
                            ? {INDIRECT_DATA[7:4], ACC[3:0]} : INDIRECT_DATA;
        end
        if (SYS_RST) begin
            r_d = '0;
            r_d.state = ST_IDLE;
        end
    end

    always_ff @(posedge MCLK) begin
        r_q <= r_d;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    sequence busy_then_done_2;
        !DONE ##1 DONE;
    endsequence

    sequence busy_then_done_3;
        !DONE ##1 !DONE ##1 DONE;
    endsequence

    sequence busy_then_done_4;
        !DONE ##1 !DONE ##1 !DONE ##1 DONE;
    endsequence

    sequence busy_then_done_5;
        !DONE [*4] ##1 DONE;
    endsequence

    carry_jump_a: assert property (
        accept && (INSTR.opcode == OP_JC || INSTR.opcode == OP_JNC) && !COND_TRUE
        |=> busy_then_done_2 ##0 RESULT.length == LEN_2)
        else $error("carry jump not taken timing wrong");

    carry_taken_a: assert property (
        accept && (INSTR.opcode == OP_JC || INSTR.opcode == OP_JNC) && COND_TRUE
        |=> busy_then_done_3 ##0 RESULT.target_valid)
        else $error("carry jump taken timing wrong");

    bit_clear_a: assert property (
        accept && INSTR.opcode == OP_BIT_CLR_JMP && COND_TRUE
        |=> RESULT.clear_bit && RESULT.length == LEN_3 ##0 busy_then_done_4)
        else $error("bit test clear jump wrong");

    cmp_indirect_a: assert property (
        accept && INSTR.opcode[7:1] == OP_CMP_IND_HI && COND_TRUE
        |=> busy_then_done_5)
        else $error("indirect compare jump timing wrong");

    dec_reg_a: assert property (
        accept && INSTR.opcode[7:3] == OP_DEC_REG_HI && !COND_TRUE
        |=> busy_then_done_2 ##0 RESULT.length == LEN_2)
        else $error("register decrement jump timing wrong");

    return_time_a: assert property (
        accept && (INSTR.opcode == OP_RET || INSTR.opcode == OP_INT_RET)
        |=> busy_then_done_5 ##0 RESULT.length == LEN_1)
        else $error("return timing wrong");

    long_branch_a: assert property (
        accept && (INSTR.opcode == OP_LONG_JMP || INSTR.opcode == OP_LONG_CALL)
        |=> RESULT.target == {$past(INSTR.operand1), $past(INSTR.operand2)}
            ##0 busy_then_done_4)
        else $error("long branch wrong");

    abs_page_a: assert property (
        accept && INSTR.opcode[3:0] == 4'h1
        |=> RESULT.target[ADDR_W-1:PAGE_LOW_BITS]
            == next_addr_q[ADDR_W-1:PAGE_LOW_BITS] ##0 busy_then_done_3)
        else $error("absolute branch left its page");

    spare_nop_a: assert property (
        accept && INSTR.opcode == OP_SPARE
        |=> DONE && RESULT.length == LEN_1 && !RESULT.taken)
        else $error("spare opcode not a no-operation");

    nibble_keep_a: assert property (
        accept && INSTR.opcode[7:1] == OP_NIBBLE_HI
        |=> RESULT.acc_out[7:4] == $past(ACC[7:4])
            && RESULT.mem_out[3:0] == $past(ACC[3:0]) ##0 busy_then_done_2)
        else $error("nibble exchange wrong");

    bank_select_a: assert property (
        accept |=> RESULT.bank_reg_addr[4:3]
            == {$past(PROGRAM_STATUS_WORD[BANK_HI_POS]),
                $past(PROGRAM_STATUS_WORD[BANK_LO_POS])})
        else $error("bank register address wrong");

    // Helper register for the page check only
    always_ff @(posedge MCLK) begin
        next_addr_q <= next_addr;
    end
endmodule

// ===== testbench/tb_cpu8_instruction_timing.sv
// Purpose: Self-checking bench for the decode and timing block.
// Assumes: DONE marks the last cycle; RESULT loads at the accepting edge.
// Notes:   One table sweeps lengths and cycles; addresses checked apart.
`timescale 1ns/1ps
module tb_cpu8_instruction_timing
    import cpu8_timing_pkg::*;
;
    logic              MCLK = 1'b0;
    logic              SYS_RST = 1'b1;
    logic              START = 1'b0;
    instr_type         INSTR = '0;
    logic [ADDR_W-1:0] INSTR_ADDR = '0;
    logic              COND_TRUE = 1'b0;
    logic [7:0]        PROGRAM_STATUS_WORD = '0;
    logic [7:0]        POINTER_VALUE = '0;
    logic [7:0]        INDIRECT_DATA = '0;
    logic [7:0]        ACC = '0;
    logic [ADDR_W-1:0] DATA_POINTER_16 = '0;
    logic              READY;
    logic              DONE;
    result_type        RESULT;
    int                bad_count = 0;
    int                n_compared = 0;
    int                ncyc;
    // Opcode, length, cycles not taken, cycles taken
    localparam logic [19:0] TBL [35] = '{
        20'h40223, 20'h50223, 20'h20334, 20'h30334, 20'h10334,
        20'hB6345, 20'hB5334, 20'hD5334, 20'hD8223, 20'h22155,
        20'h32155, 20'h12344, 20'h02344, 20'h11233, 20'h01233,
        20'h93133, 20'h83133, 20'hE0133, 20'hE2133, 20'hF0133,
        20'hF3133, 20'hD6122, 20'h85333, 20'h90333, 20'h53333,
        20'h43333, 20'h63333, 20'h52222, 20'h42222, 20'h62222,
        20'h80233, 20'h73133, 20'hC0222, 20'hD0222, 20'hA5111};

    always #20 MCLK = ~MCLK;

    cpu8_instruction_timing cpu8_instruction_timing_i (
        .MCLK(MCLK), .SYS_RST(SYS_RST), .START(START), .INSTR(INSTR),
        .INSTR_ADDR(INSTR_ADDR), .COND_TRUE(COND_TRUE),
        .PROGRAM_STATUS_WORD(PROGRAM_STATUS_WORD), .POINTER_VALUE(POINTER_VALUE),
        .INDIRECT_DATA(INDIRECT_DATA), .ACC(ACC), .DATA_POINTER_16(DATA_POINTER_16),
        .READY(READY), .DONE(DONE), .RESULT(RESULT));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Bounded wait so a lost DONE cannot hang the sweep
    task automatic run(input logic [7:0] op, input logic [7:0] o1, input logic [7:0] o2,
                       input logic [15:0] addr, input logic c);
        @(posedge MCLK);
        START <= 1'b1;
        INSTR <= {op, o1, o2};
        INSTR_ADDR <= addr;
        COND_TRUE <= c;
        @(posedge MCLK);
        START <= 1'b0;
        ncyc = 1;
        #1;
        while (DONE !== 1'b1 && ncyc < 12) begin
            @(posedge MCLK);
            #1;
            ncyc++;
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_table();
        logic [19:0] e;
        for (int i = 0; i < 35; i++) begin
            for (int c = 0; c < 2; c++) begin
                e = TBL[i];
                run(e[19:12], 8'h00, 8'h00, 16'h0100, c[0]);
                check("length", RESULT.length, e[11:8]);
                check("cycles", ncyc, c ? e[3:0] : e[7:4]);
                check("cyc field", RESULT.cycles, ncyc);
                if (e[19:12] == 8'h10) begin
                    check("clear bit", RESULT.clear_bit, c);
                end
            end
        end
    endtask

    task automatic t_targets();
        run(8'h40, 8'hFE, 8'h00, 16'h1000, 1'b1);
        check("jc target", RESULT.target, 16'h1000);
        check("jc valid", RESULT.target_valid, 1'b1);
        run(8'h30, 8'h05, 8'h80, 16'h0200, 1'b1);
        check("jnb target", RESULT.target, 16'h0183);
        run(8'h80, 8'h7F, 8'h00, 16'h00FF, 1'b0);
        check("short target", RESULT.target, 16'h0180);
        check("short taken", RESULT.taken, 1'b1);
        run(8'hE1, 8'h34, 8'h00, 16'h07FE, 1'b0);
        check("page target", RESULT.target, 16'h0F34);
        run(8'h02, 8'h1F, 8'hEE, 16'h0040, 1'b0);
        check("long target", RESULT.target, 16'h1FEE);
        @(posedge MCLK);
        ACC <= 8'h10;
        DATA_POINTER_16 <= 16'h1FF8;
        run(8'h73, 8'h00, 8'h00, 16'h0300, 1'b0);
        check("ind target", RESULT.target, 16'h2008);
        run(8'h83, 8'h00, 8'h00, 16'h0010, 1'b0);
        check("pc read", RESULT.code_addr, 16'h0021);
        run(8'h93, 8'h00, 8'h00, 16'h0010, 1'b0);
        check("dp read", RESULT.code_addr, 16'h2008);
    endtask

    task automatic t_operands();
        for (int b = 0; b < 4; b++) begin
            @(posedge MCLK);
            PROGRAM_STATUS_WORD <= 8'hE7 | 8'(b << 3);
            run(8'hE8 | 8'(2 * b + 1), 8'h00, 8'h00, 16'h0000, 1'b0);
            check("bank reg", RESULT.bank_reg_addr, 10 * b + 1);
            run(8'hE6 | 8'(b & 1), 8'h00, 8'h00, 16'h0000, 1'b0);
            check("pointer reg", RESULT.pointer_reg_addr, 8 * b + (b & 1));
        end
        for (int d = 8'h7F; d < 8'h81; d++) begin
            run(8'hE5, 8'(d), 8'h00, 16'h0000, 1'b0);
            check("space select", RESULT.direct_is_special, d >= 8'h80);
        end
        @(posedge MCLK);
        ACC <= 8'h5C;
        INDIRECT_DATA <= 8'hA7;
        POINTER_VALUE <= 8'h9B;
        run(8'hD7, 8'h00, 8'h00, 16'h0000, 1'b0);
        check("acc nibble", RESULT.acc_out, 8'h57);
        check("mem nibble", RESULT.mem_out, 8'hAC);
        check("ind addr", RESULT.data_addr, 8'h9B);
    endtask

    initial begin
        repeat (10) @(posedge MCLK);
        SYS_RST <= 1'b0;
        #1;
        check("reset ready", READY, 1'b1);
        check("reset done", DONE, 1'b0);
        check("reset result", RESULT == '0, 1'b1);
        t_table();
        t_targets();
        t_operands();
        summarize();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge MCLK);
        bad_count++;
        summarize();
    end
endmodule
